// ---- core/acrt_regs.svh ----
/*
 * Timing constants for the conversion-control and readout sequencer.
 * Assumes a 125 MHz core clock (8 ns period).
 */
`ifndef ACRT_REGS_SVH
`define ACRT_REGS_SVH
`define ACRT_CLK_PS           8000
// short enough to finish, with the busy tail, before the read-after-convert frame at 508 ns
`define ACRT_CONV_NS          480
`define ACRT_CONV_CYC         ((`ACRT_CONV_NS * 1000) / `ACRT_CLK_PS)
`define ACRT_EOC_BUSY_NS      10
`define ACRT_EOC_BUSY_CYC     (((`ACRT_EOC_BUSY_NS * 1000) + `ACRT_CLK_PS - 1) / `ACRT_CLK_PS)
`define ACRT_BUSY_MAX_NS      550
`define ACRT_BUSY_MAX_CYC     ((`ACRT_BUSY_MAX_NS * 1000) / `ACRT_CLK_PS)
`define ACRT_RST_BUSY_NS      500
`define ACRT_RST_BUSY_CYC     ((`ACRT_RST_BUSY_NS * 1000) / `ACRT_CLK_PS)
`define ACRT_SYNC_RDC_NS      135
`define ACRT_SYNC_RDC_CYC     ((`ACRT_SYNC_RDC_NS * 1000) / `ACRT_CLK_PS)
`define ACRT_SYNC_RAC_NS      508
`define ACRT_SYNC_RAC_CYC     ((`ACRT_SYNC_RAC_NS * 1000) / `ACRT_CLK_PS)
`define ACRT_RES_W            18
`define ACRT_CNT_W            12
`endif

// ---- core/acrt_pkg.sv ----
/*
 * Types for the conversion-control and readout sequencer.
 * Assumes acrt_regs.svh is compiled alongside.
 */
package acrt_pkg;
  typedef enum logic [1:0] {
    ACRT_MODE_PARALLEL,
    ACRT_MODE_MSER_RDC,
    ACRT_MODE_MSER_RAC,
    ACRT_MODE_SSER
  } acrt_mode_type;
  typedef struct packed {
    logic sdo;
    logic sclk;
    logic frame;
  } acrt_ser_type;
  typedef struct packed {
    logic sdo;
    logic sclk;
    logic frame;
  } acrt_ser_oe_type;
endpackage : acrt_pkg

// ---- core/acrt_seq.sv ----
/*
 * Conversion control and result readout sequencer, single 125 MHz clock.
 * Assumes the core supplies the finished 18-bit code; convert start and
 * chip select are synchronised here before use, mode and divider are not.
 */
// Behaviour
// - busy rises after convert start and stays high at most 550 ns except in master read-after-convert.
// - the result is valid on the outputs no later than 550 ns after convert start.
// - data is valid at least 2 ns before busy falls.
// - busy falls no sooner than 10 ns after the internal conversion ends.
// - each result is offered as soon as its conversion ends, with no pipeline latency.
// - after reset, busy is held high for about 500 ns before operation resumes.
// - in master read-during-convert, the frame marker asserts about 135 ns after convert start.
// - in master read-after-convert, the frame marker asserts about 508 ns after start and busy falls after it ends.
// - in master read-after-convert, the divider code selects serial clock periods of 16, 16, 32 or 64 ns (code 00 rounded up from 8 ns).
// - in master read-after-convert, busy stays high at most 0.84, 1.14, 1.72 or 2.88 us per divider code.
// - the first serial clock edge follows the frame marker, which falls together with the last (falling) clock edge.
// - chip select high releases serial data, frame marker and serial clock within 10 ns; here the two-stage synchroniser takes up to 16 ns.
// - chip select low starts driving frame marker, clock and data within 10 ns in master mode; here the two-stage synchroniser takes up to 16 ns.
`timescale 1ns/1ps
`include "acrt_regs.svh"
module acrt_seq (
  // clock and reset
  input  wire logic                      mclk_in,
  input  wire logic                      rst_n_in,
  // host control pins
  input  wire logic                      convert_start_n_in,
  input  wire logic                      chip_select_n_in,
  input  wire acrt_pkg::acrt_mode_type   mode_in,
  input  wire logic [1:0]                serial_clock_divider_in,
  // converter core result
  input  wire logic [`ACRT_RES_W-1:0]    core_result_in,
  // outputs
  output logic                           busy_out,
  output logic [`ACRT_RES_W-1:0]         data_out,
  output acrt_pkg::acrt_ser_type         ser_out,
  output acrt_pkg::acrt_ser_oe_type      ser_oe_out
);
  import acrt_pkg::*;

  typedef enum {ST_RESET, ST_IDLE, ST_CONV, ST_HOLD, ST_WAITF, ST_SHIFT, ST_TAIL} acrt_state_type;

  // half period in cycles of 8 ns: 1,1,2,4 -> periods 16..64; code 00 gives 8 ns rounded to 2 cycles
  function automatic logic [2:0] half_cyc(input logic [1:0] d);
    case (d)
      2'h0:    half_cyc = 3'h1;
      2'h1:    half_cyc = 3'h1;
      2'h2:    half_cyc = 3'h2;
      default: half_cyc = 3'h4;
    endcase
  endfunction : half_cyc

  // ==================================================
  // pin synchronisers
  logic [1:0] cnv_s_r, cs_s_r;
  logic       cnv_d_r;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnv_s_r <= 2'h3;
      cs_s_r  <= 2'h3;
      cnv_d_r <= 1'b1;
    end else begin
      cnv_s_r <= {cnv_s_r[0], convert_start_n_in};
      cs_s_r  <= {cs_s_r[0], chip_select_n_in};
      cnv_d_r <= cnv_s_r[1];
    end
  end
  wire cnv_fall = cnv_d_r & ~cnv_s_r[1];
  wire cs_n     = cs_s_r[1];
  wire master   = (mode_in == ACRT_MODE_MSER_RDC) || (mode_in == ACRT_MODE_MSER_RAC);

  // ==================================================
  // sequencer
  acrt_state_type               st_r, st_nxt;
  logic [`ACRT_CNT_W-1:0]       cnt_r, cnt_nxt;
  logic [`ACRT_RES_W-1:0]       data_r, data_nxt, sh_r, sh_nxt;
  logic [4:0]                   bit_r, bit_nxt;
  logic [2:0]                   div_r, div_nxt;
  logic                         busy_r, busy_nxt, frame_r, frame_nxt, sclk_r, sclk_nxt;
  logic                         rac_r, rac_nxt;

  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r + 1'b1;
    data_nxt  = data_r;
    sh_nxt    = sh_r;
    bit_nxt   = bit_r;
    div_nxt   = div_r;
    busy_nxt  = busy_r;
    frame_nxt = frame_r;
    sclk_nxt  = sclk_r;
    rac_nxt   = rac_r;
    case (st_r)
      ST_RESET: begin
        busy_nxt = 1'b1;
        if (cnt_r >= `ACRT_CNT_W'(`ACRT_RST_BUSY_CYC - 1)) begin
          st_nxt   = ST_IDLE;
          busy_nxt = 1'b0;
        end
      end
      ST_IDLE: begin
        cnt_nxt = '0;
        // start raises busy; relied on, starts ignored while busy
        if (cnv_fall) begin
          st_nxt   = ST_CONV;
          busy_nxt = 1'b1;
          rac_nxt  = (mode_in == ACRT_MODE_MSER_RAC);
        end
      end
      ST_CONV: begin
        // read-during-convert frame marker at 135 ns, shifting previous result
        if (!rac_r && master && cnt_r == `ACRT_CNT_W'(`ACRT_SYNC_RDC_CYC - 1)) begin
          frame_nxt = 1'b1;
          sh_nxt    = data_r;
          bit_nxt   = 5'(`ACRT_RES_W);
          div_nxt   = half_cyc(2'h0);
        end
        // reload of one toggles every cycle, so all 18 bits leave before the conversion ends
        if (frame_r && !rac_r && div_r != 3'h1) div_nxt = div_r - 1'b1;
        else if (frame_r && !rac_r) begin
          // serial clock only while frame is up
          div_nxt  = half_cyc(2'h0);
          sclk_nxt = ~sclk_r;
          if (sclk_r) begin
            sh_nxt  = {sh_r[`ACRT_RES_W-2:0], 1'b0};
            bit_nxt = bit_r - 1'b1;
            if (bit_r == 5'h1) frame_nxt = 1'b0;
          end
        end
        if (cnt_r == `ACRT_CNT_W'(`ACRT_CONV_CYC - 1)) begin
          data_nxt = core_result_in;
          st_nxt   = ST_HOLD;
          cnt_nxt  = '0;
        end
      end
      ST_HOLD: begin
        // data stable, busy drops 2 cycles (16 ns) after end of conversion, except in read-after-convert
        if (cnt_r == `ACRT_CNT_W'(`ACRT_EOC_BUSY_CYC - 1)) begin
          cnt_nxt = '0;
          if (rac_r) st_nxt = ST_WAITF;
          else begin
            st_nxt    = ST_IDLE;
            busy_nxt  = 1'b0;
            frame_nxt = 1'b0;
            sclk_nxt  = 1'b0;
          end
        end
      end
      ST_WAITF: begin
        // read-after-convert frame marker at 508 ns from start
        if (cnt_r == `ACRT_CNT_W'(`ACRT_SYNC_RAC_CYC - `ACRT_CONV_CYC - `ACRT_EOC_BUSY_CYC - 1)) begin
          st_nxt    = ST_SHIFT;
          frame_nxt = 1'b1;
          sh_nxt    = data_r;
          bit_nxt   = 5'(`ACRT_RES_W);
          div_nxt   = half_cyc(serial_clock_divider_in);
        end
      end
      ST_SHIFT: begin
        // divided clock, 18 bits bound busy time
        if (div_r != 3'h1) div_nxt = div_r - 1'b1;
        else begin
          div_nxt  = half_cyc(serial_clock_divider_in);
          sclk_nxt = ~sclk_r;
          if (sclk_r) begin
            sh_nxt  = {sh_r[`ACRT_RES_W-2:0], 1'b0};
            bit_nxt = bit_r - 1'b1;
            if (bit_r == 5'h1) begin
              st_nxt    = ST_TAIL;
              frame_nxt = 1'b0;
            end
          end
        end
      end
      ST_TAIL: begin
        st_nxt   = ST_IDLE;
        busy_nxt = 1'b0;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r    <= ST_RESET;
      cnt_r   <= '0;
      data_r  <= '0;
      sh_r    <= '0;
      bit_r   <= 5'h0;
      div_r   <= 3'h0;
      busy_r  <= 1'b1;
      frame_r <= 1'b0;
      sclk_r  <= 1'b0;
      rac_r   <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      data_r  <= data_nxt;
      sh_r    <= sh_nxt;
      bit_r   <= bit_nxt;
      div_r   <= div_nxt;
      busy_r  <= busy_nxt;
      frame_r <= frame_nxt;
      sclk_r  <= sclk_nxt;
      rac_r   <= rac_nxt;
    end
  end

  // ==================================================
  // outputs
  assign busy_out  = busy_r;
  assign data_out  = data_r;
  assign ser_out   = '{sdo: sh_r[`ACRT_RES_W-1], sclk: sclk_r, frame: frame_r};
  // one synchronised chip select gates all serial drivers
  assign ser_oe_out = '{sdo: ~cs_n && mode_in != ACRT_MODE_PARALLEL, sclk: ~cs_n && master, frame: ~cs_n && master};

  // ==================================================
  // checks
  logic [`ACRT_CNT_W-1:0] busy_len_r;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) busy_len_r <= '0;
    else if (busy_r) busy_len_r <= busy_len_r + 1'b1;
    else busy_len_r <= '0;
  end
  busy_max_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (busy_r && !rac_r && st_r != ST_RESET) |-> busy_len_r <= `ACRT_CNT_W'(`ACRT_BUSY_MAX_CYC))
    else $error("busy too long");
  data_valid_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    cnv_fall && st_r == ST_IDLE |-> ##[1:68] (st_r == ST_HOLD))
    else $error("result late");
  data_before_busy_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $fell(busy_r) |-> $stable(data_r))
    else $error("data moved at busy fall");
  eoc_busy_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (st_r == ST_CONV && st_nxt == ST_HOLD) |=> busy_r)
    else $error("busy fell at conversion end");
  no_latency_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (st_r == ST_CONV && st_nxt == ST_HOLD) |=> data_r == $past(core_result_in))
    else $error("result not current");
  frame_rdc_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (st_r == ST_CONV && !rac_r && master && cnt_r == `ACRT_CNT_W'(`ACRT_SYNC_RDC_CYC - 1)) |=> frame_r)
    else $error("frame not asserted");
  busy_after_frame_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (rac_r && $fell(busy_r)) |-> !frame_r && $past(!frame_r))
    else $error("busy fell before frame end");
  sclk_in_frame_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $rose(sclk_r) |-> frame_r)
    else $error("clock edge outside frame");
  cs_release_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $rose(cs_s_r[1]) |-> ser_oe_out == '0)
    else $error("serial pins still driven");
endmodule : acrt_seq

// ---- tb/acrt_host.sv ----
/*
 * Host-side serial reader for the readout sequencer.
 * Assumes serial lines are sampled in the core clock domain.
 */
`timescale 1ns/1ps
`include "acrt_regs.svh"
module acrt_host (
  // clock and reset
  input  wire logic                   mclk_in,
  input  wire logic                   rst_n_in,
  // serial pins from the device
  input  wire acrt_pkg::acrt_ser_type    ser_in,
  input  wire acrt_pkg::acrt_ser_oe_type oe_in,
  // captured frame
  output logic [`ACRT_RES_W-1:0]      word_out,
  output int                          bits_out,
  output int                          min_per_out
);
  import acrt_pkg::*;
  // ============================================================
  // released lines read low, as if pulled down on the board
  logic sdo_w, sclk_w, frame_w, sclk_q, frame_q;
  int   since;
  assign sdo_w   = oe_in.sdo & ser_in.sdo;
  assign sclk_w  = oe_in.sclk & ser_in.sclk;
  assign frame_w = oe_in.frame & ser_in.frame;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_q <= 1'b0; frame_q <= 1'b0; since <= 0;
      word_out <= '0; bits_out <= 0; min_per_out <= 999;
    end else begin
      sclk_q  <= sclk_w;
      frame_q <= frame_w;
      since   <= since + 1;
      if (frame_w && !frame_q) begin
        bits_out <= 0; min_per_out <= 999;
      end else if (frame_w && sclk_w && !sclk_q) begin
        word_out <= {word_out[`ACRT_RES_W-2:0], sdo_w};
        bits_out <= bits_out + 1;
        if (bits_out > 0 && since < min_per_out) min_per_out <= since;
        since <= 1;
      end
    end
  end
endmodule : acrt_host

// ---- tb/testbench.sv ----
/*
 * Self-checking bench for the readout sequencer.
 * Assumes a 125 MHz clock and the host reader model beside it.
 */
`timescale 1ns/1ps
`include "acrt_regs.svh"
module testbench;
  import acrt_pkg::*;
  logic                    mclk_in = 1'b0;
  logic                    rst_n_in = 1'b0;
  logic                    convert_start_n_in = 1'b1;
  logic                    chip_select_n_in = 1'b0;
  acrt_mode_type           mode_in = ACRT_MODE_PARALLEL;
  logic [1:0]              serial_clock_divider_in = 2'h0;
  logic [`ACRT_RES_W-1:0]  core_result_in = '0;
  logic                    busy_out;
  logic [`ACRT_RES_W-1:0]  data_out, host_word, exp_r;
  acrt_ser_type            ser_out;
  acrt_ser_oe_type         ser_oe_out;
  int host_bits, host_min_per, errors = 0, total_checks = 0;
  int n, busy_cyc, rise_n, dv_n, fr_first, fr_last;
  int lim[4] = '{105, 142, 215, 360};
  int minp[4] = '{8, 16, 32, 64};
  always #4 mclk_in = ~mclk_in;
  acrt_seq acrt_seq_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .convert_start_n_in(convert_start_n_in),
    .chip_select_n_in(chip_select_n_in), .mode_in(mode_in), .serial_clock_divider_in(serial_clock_divider_in),
    .core_result_in(core_result_in), .busy_out(busy_out), .data_out(data_out), .ser_out(ser_out),
    .ser_oe_out(ser_oe_out));
  acrt_host acrt_host_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .ser_in(ser_out), .oe_in(ser_oe_out),
    .word_out(host_word), .bits_out(host_bits), .min_per_out(host_min_per));
  // ============================================================
  task automatic tick();
    @(posedge mclk_in);
    #1;
  endtask : tick
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task automatic fail_wait(input string nm);
    errors++;
    $display("Error %s expected settle seen timeout", nm);
    summarize();
  endtask : fail_wait
  task automatic chk_val(input string nm, input logic [17:0] exp, input logic [17:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_val
  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    total_checks++;
    if (got < lo || got > hi) begin
      errors++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : chk_rng
  // one conversion, timed in cycles from the strobe's fall; next start only after busy drops
  task automatic conv(input acrt_mode_type m, input logic [1:0] d, input logic [17:0] r);
    rise_n = 0; dv_n = 0; fr_first = 0; fr_last = 0;
    mode_in = m; serial_clock_divider_in = d; core_result_in = r;
    tick();
    convert_start_n_in = 1'b0;
    tick();
    tick();
    convert_start_n_in = 1'b1;
    n = 2;
    while ((rise_n == 0 || busy_out !== 1'b0) && n < 600) begin
      if (busy_out === 1'b1 && rise_n == 0) rise_n = n;
      if (data_out === r && dv_n == 0) dv_n = n;
      if ((ser_out.frame & ser_oe_out.frame) === 1'b1) begin
        if (fr_first == 0) fr_first = n;
        fr_last = n;
      end
      tick();
      n++;
    end
    if (n >= 600) fail_wait("busy_out");
    busy_cyc = n;
  endtask : conv
  // ============================================================
  initial begin
    tick();
    tick();
    rst_n_in = 1'b1;
    n = 0;
    while (busy_out !== 1'b0 && n < 200) begin
      tick();
      n++;
    end
    if (n >= 200) fail_wait("reset busy_out");
    chk_rng("reset_busy_cycles", 58, 66, n);
    conv(ACRT_MODE_PARALLEL, 2'h0, 18'h2A5C3);
    chk_rng("par_busy_cycles", 1, 68, busy_cyc - rise_n);
    chk_rng("par_data_cycle", 1, 68, dv_n);
    chk_rng("par_data_before_busy", 1, busy_cyc - 1, dv_n);
    chk_rng("par_eoc_busy_cycles", `ACRT_EOC_BUSY_CYC, 68, busy_cyc - dv_n);
    chk_val("par_data_out", 18'h2A5C3, data_out);
    conv(ACRT_MODE_SSER, 2'h1, 18'h0F0F1);
    chk_rng("sser_busy_cycles", 1, 68, busy_cyc - rise_n);
    chk_val("sser_data_out", 18'h0F0F1, data_out);
    conv(ACRT_MODE_MSER_RDC, 2'h0, 18'h1C3E7);
    chk_rng("rdc_busy_cycles", 1, 68, busy_cyc - rise_n);
    chk_rng("rdc_frame_start", 12, 26, fr_first);
    chk_val("rdc_word", 18'h0F0F1, host_word);
    chk_rng("rdc_bits", 18, 18, host_bits);
    chk_val("rdc_data_out", 18'h1C3E7, data_out);
    for (int d = 0; d < 4; d++) begin
      exp_r = 18'h15A5A + 18'(d);
      conv(ACRT_MODE_MSER_RAC, 2'(d), exp_r);
      chk_rng("rac_busy_cycles", 1, lim[d], busy_cyc - rise_n);
      chk_rng("rac_frame_start", 58, 72, fr_first);
      chk_rng("rac_frame_before_busy", 1, busy_cyc - 1, fr_last);
      chk_val("rac_word", exp_r, host_word);
      chk_rng("rac_bits", 18, 18, host_bits);
      chk_rng("rac_sclk_ns", minp[d], 1000, host_min_per * 8);
    end
    chip_select_n_in = 1'b1;
    tick();
    tick();
    tick();
    chk_val("oe_released", 18'h00000, {15'h0000, ser_oe_out});
    chip_select_n_in = 1'b0;
    tick();
    tick();
    tick();
    chk_val("oe_driving", 18'h00007, {15'h0000, ser_oe_out});
    summarize();
  end
endmodule : testbench
